// ===== rtl/digital_input_scan_control.sv
`timescale 1ns/100ps
// Contract
// - Channel-card command 01 picks random selection, 02 picks sequential.
// - Channel-card command 00 links the block-transfer controller and forces random.
// - Eight-bit select code names channels 1 through 256.
// - Sequential mode gets only the final channel; device generates 1..final.
// - Channel-card sense 00 is true when sequential scan is at final channel.
// - After the final channel the sequence wraps to channel 1.
// - Converter command 01 starts one input under program control.
// - Converter 02 allows external or timer starts; 03 locks them out.
// - Converter sense 00 reports data ready; host polls before reading.
// - Clear-and-input read also clears data ready.
// - Data ready waits 20 us after a new channel selection.
// - Timer takes 16-bit count, decrements each microsecond, pulses at zero.
// - Continuous timer reloads from buffer and restarts at once.
// - Single-cycle timer stops until an external trigger; mode is wired.
// - Converter sense 01 is true once the timer has reached zero.
// - Timer-zero sense clears once a query has seen it true.
// - Converter sense 02 returns the utility input.
// - All data words are read at the converter address, plain or clearing.
// - Converter command 00 links converter to the block-transfer controller.
// - Own card channel selected: card word replaces converter word.
// - Strobe captures external words periodically, or external strobe instead.
module digital_input_scan_control
    import scan_ctrl_pkg::*;
#(
    parameter logic [CODE_W-1:0] CARD_BASE = 8'h00
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic [DATA_W-1:0] adc_data_i,
    input wire logic [CARD_CHANNELS*DATA_W-1:0] ext_word_i,
    input wire logic ext_strobe_i,
    input wire logic strobe_ext_sel_i,
    input wire logic ext_start_i,
    input wire logic utility_i,
    input wire logic timer_continuous_i,
    input wire logic timer_trigger_i,
    input wire logic bic_chan_valid_i,
    input wire logic [CODE_W-1:0] bic_chan_i,
    output logic bic_mux_en_o,
    output logic bic_adc_en_o,
    output logic bic_data_valid_o,
    output logic [DATA_W-1:0] bic_data_o,
    output logic card_drive_o,
    output logic timer_pulse_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic seq_mode;
    logic seq_started;
    logic [CODE_W-1:0] final_code;
    logic [CODE_W-1:0] active_chan;
    logic [CODE_W-1:0] next_seq_chan;
    logic [CODE_W-1:0] card_offset;
    logic own_channel;
    logic end_of_scan;
    logic ext_start_en;
    logic [SLOW_CNT_W-1:0] settle_cnt;
    logic [SLOW_CNT_W-1:0] strobe_cnt;
    logic strobe_tick;
    logic capture_strobe;
    logic [DATA_W-1:0] card_regs [CARD_CHANNELS];
    conv_state_e conv_state;
    logic [DATA_W-1:0] data_word;
    logic data_ready;
    logic timer_zero;
    logic timer_pulse;
    logic start_req;
    logic start_take;
    logic conv_done;
    logic mux_cmd_wr;
    logic adc_cmd_wr;
    logic select_wr;
    logic timer_wr;
    logic clear_rd;
    logic status_rd;
    logic random_select;
    logic [CODE_W-1:0] random_code;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] next_word;

    ////////////////////////////////////////////////////////////////////////
    // Register port decode

    assign mux_cmd_wr = wr_i && (addr_i == OFS_MUX_CMD);
    assign select_wr = wr_i && (addr_i == OFS_MUX_SELECT);
    assign adc_cmd_wr = wr_i && (addr_i == OFS_ADC_CMD);
    assign timer_wr = wr_i && (addr_i == OFS_TIMER_BUF);
    assign clear_rd = rd_i && (addr_i == OFS_DATA_CLEAR);
    assign status_rd = rd_i && (addr_i == OFS_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Channel selection mode and controller link

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            seq_mode <= 1'b0;
            bic_mux_en_o <= 1'b0;
        end
        else if (mux_cmd_wr)
        begin
            case (wr_data_i[1:0])
                FN_BIC:
                begin
                    seq_mode <= 1'b0;
                    bic_mux_en_o <= 1'b1;
                end
                FN_RANDOM:
                begin
                    seq_mode <= 1'b0;
                    bic_mux_en_o <= 1'b0;
                end
                FN_SEQUENTIAL:
                begin
                    seq_mode <= 1'b1;
                    bic_mux_en_o <= 1'b0;
                end
                default:
                begin
                    seq_mode <= seq_mode;
                    bic_mux_en_o <= bic_mux_en_o;
                end
            endcase
        end
    end

    // A select code from the controller counts only while it is linked
    assign random_select = !seq_mode
        && (select_wr || (bic_mux_en_o && bic_chan_valid_i));
    assign random_code = select_wr ? wr_data_i[CODE_W-1:0] : bic_chan_i;

    ////////////////////////////////////////////////////////////////////////
    // Channel counter

    assign next_seq_chan = (!seq_started || active_chan == final_code)
        ? FIRST_CODE : active_chan + 1'b1;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            final_code <= FIRST_CODE;
            seq_started <= 1'b0;
        end
        else if (seq_mode && select_wr)
        begin
            final_code <= wr_data_i[CODE_W-1:0];
            seq_started <= 1'b0;
        end
        else if (mux_cmd_wr)
            seq_started <= 1'b0;
        else if (seq_mode && start_take)
            seq_started <= 1'b1;
    end

    // Code 0 is channel 1, code 255 is channel 256
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            active_chan <= FIRST_CODE;
        else if (random_select)
            active_chan <= random_code;
        else if (seq_mode && start_take)
            active_chan <= next_seq_chan;
    end

    assign end_of_scan = seq_mode && seq_started && (active_chan == final_code);

    ////////////////////////////////////////////////////////////////////////
    // Settling time after any channel change

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            settle_cnt <= '0;
        else if (random_select || (seq_mode && start_take))
            settle_cnt <= SETTLE_LOAD;
        else if (settle_cnt != '0)
            settle_cnt <= settle_cnt - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Input card storage registers

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            strobe_cnt <= '0;
        else if (strobe_tick)
            strobe_cnt <= '0;
        else
            strobe_cnt <= strobe_cnt + 1'b1;
    end

    assign strobe_tick = (strobe_cnt == STROBE_LAST);
    assign capture_strobe = strobe_ext_sel_i ? ext_strobe_i : strobe_tick;

    // Old contents are read in the same edge as a capture, so a word never tears
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < CARD_CHANNELS; i++)
                card_regs[i] <= '0;
        end
        else if (capture_strobe)
        begin
            for (int i = 0; i < CARD_CHANNELS; i++)
                card_regs[i] <= ext_word_i[i*DATA_W +: DATA_W];
        end
    end

    assign card_offset = active_chan - CARD_BASE;
    assign own_channel = (card_offset < CODE_W'(CARD_CHANNELS));
    assign next_word = own_channel
        ? card_regs[card_offset[CARD_IDX_W-1:0]] : adc_data_i;

    ////////////////////////////////////////////////////////////////////////
    // Converter control

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ext_start_en <= 1'b0;
            bic_adc_en_o <= 1'b0;
        end
        else if (adc_cmd_wr)
        begin
            case (wr_data_i[1:0])
                FN_BIC:
                    bic_adc_en_o <= 1'b1;
                FN_EXT_ENABLE:
                    ext_start_en <= 1'b1;
                FN_EXT_LOCK:
                    ext_start_en <= 1'b0;
                default:
                    ext_start_en <= ext_start_en;
            endcase
        end
    end

    assign start_req = (adc_cmd_wr && wr_data_i[1:0] == FN_START)
        || (ext_start_en && (ext_start_i || timer_pulse));

    // Starts that arrive while a conversion is pending are dropped
    assign start_take = start_req && (conv_state == CONV_IDLE);
    assign conv_done = (conv_state == CONV_SETTLE) && (settle_cnt == '0);

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            conv_state <= CONV_IDLE;
        else
        begin
            case (conv_state)
                CONV_IDLE:
                    if (start_take)
                        conv_state <= CONV_SETTLE;
                CONV_SETTLE:
                    if (conv_done)
                        conv_state <= CONV_IDLE;
                default:
                    conv_state <= CONV_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            data_word <= '0;
            card_drive_o <= 1'b0;
        end
        else if (conv_done)
        begin
            data_word <= next_word;
            card_drive_o <= own_channel;
        end
    end

    // A finished word raises ready unless the converter is linked, even when a clearing read lands in that cycle
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            data_ready <= 1'b0;
        else if (conv_done && !bic_adc_en_o)
            data_ready <= 1'b1;
        else if (clear_rd)
            data_ready <= 1'b0;
    end

    // Linked to the controller, each word goes out without an input read
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            bic_data_valid_o <= 1'b0;
            bic_data_o <= '0;
        end
        else
        begin
            bic_data_valid_o <= conv_done && bic_adc_en_o;
            if (conv_done)
                bic_data_o <= next_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interval timer

    interval_timer timer_inst (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .load_i(timer_wr),
        .load_value_i(wr_data_i),
        .continuous_i(timer_continuous_i),
        .trigger_i(timer_trigger_i),
        .zero_pulse_o(timer_pulse)
    );

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            timer_pulse_o <= 1'b0;
        else
            timer_pulse_o <= timer_pulse;
    end

    // Set wins over the self-clear from a status read
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            timer_zero <= 1'b0;
        else if (timer_pulse)
            timer_zero <= 1'b1;
        else if (status_rd && timer_zero)
            timer_zero <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb
    begin
        status_word = '0;
        status_word[ST_END_OF_SCAN] = end_of_scan;
        status_word[ST_DATA_READY] = data_ready;
        status_word[ST_TIMER_ZERO] = timer_zero;
        status_word[ST_UTILITY] = utility_i;
        status_word[ST_SEQ_MODE] = seq_mode;
        status_word[ST_BUSY] = (conv_state != CONV_IDLE);
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            rd_data_o <= '0;
        else if (rd_i)
        begin
            case (addr_i)
                OFS_DATA:
                    rd_data_o <= data_word;
                OFS_DATA_CLEAR:
                    rd_data_o <= data_word;
                OFS_STATUS:
                    rd_data_o <= status_word;
                OFS_MUX_SELECT:
                    rd_data_o <= {{(DATA_W-CODE_W){1'b0}}, active_chan};
                default:
                    rd_data_o <= '0;
            endcase
        end
        else
            rd_data_o <= '0;
    end

endmodule : digital_input_scan_control

// ===== shared/scan_ctrl_pkg.sv
package scan_ctrl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CODE_W = 8;

    // Register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFS_MUX_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MUX_SELECT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ADC_CMD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TIMER_BUF = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DATA_CLEAR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

    // Function codes, low two bits of a command write
    localparam logic [1:0] FN_BIC = 2'h0;
    localparam logic [1:0] FN_RANDOM = 2'h1;
    localparam logic [1:0] FN_SEQUENTIAL = 2'h2;
    localparam logic [1:0] FN_START = 2'h1;
    localparam logic [1:0] FN_EXT_ENABLE = 2'h2;
    localparam logic [1:0] FN_EXT_LOCK = 2'h3;

    // Status register bit positions
    localparam int ST_END_OF_SCAN = 0;
    localparam int ST_DATA_READY = 1;
    localparam int ST_TIMER_ZERO = 2;
    localparam int ST_UTILITY = 3;
    localparam int ST_SEQ_MODE = 4;
    localparam int ST_BUSY = 5;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int SETTLE_NS = 20000;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_NS = 20000;
    localparam int STROBE_CYCLES = STROBE_NS / CLK_PERIOD_NS;
    localparam int US_CNT_W = 7;
    localparam int SLOW_CNT_W = 12;
    localparam logic [US_CNT_W-1:0] US_LAST = US_CNT_W'(US_CYCLES - 1);
    localparam logic [SLOW_CNT_W-1:0] SETTLE_LOAD = SLOW_CNT_W'(SETTLE_CYCLES);
    localparam logic [SLOW_CNT_W-1:0] STROBE_LAST = SLOW_CNT_W'(STROBE_CYCLES - 1);

    // Input card geometry
    localparam int CARD_CHANNELS = 4;
    localparam int CARD_IDX_W = 2;
    localparam logic [CODE_W-1:0] FIRST_CODE = 8'h00;

    typedef enum logic [1:0] {CONV_IDLE, CONV_SETTLE} conv_state_e;

endpackage : scan_ctrl_pkg

// ===== rtl/interval_timer.sv
`timescale 1ns/100ps
module interval_timer
    import scan_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire logic [DATA_W-1:0] load_value_i,
    input wire logic continuous_i,
    input wire logic trigger_i,
    output logic zero_pulse_o
);

    logic [US_CNT_W-1:0] us_cnt;
    logic [DATA_W-1:0] buffer;
    logic [DATA_W-1:0] count;
    logic running;
    logic tick;

    assign tick = (us_cnt == US_LAST);

    // Microsecond time base, realigned on every load
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            us_cnt <= '0;
        else if (load_i || tick)
            us_cnt <= '0;
        else
            us_cnt <= us_cnt + 1'b1;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            buffer <= '0;
        else if (load_i)
            buffer <= load_value_i;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            count <= '0;
            running <= 1'b0;
        end
        else if (load_i)
        begin
            count <= load_value_i;
            running <= (load_value_i != '0);
        end
        else if (!running && !continuous_i && trigger_i && buffer != '0)
        begin
            count <= buffer;
            running <= 1'b1;
        end
        else if (running && tick)
        begin
            if (count == DATA_W'(1))
            begin
                count <= buffer;
                running <= continuous_i;
            end
            else
                count <= count - 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            zero_pulse_o <= 1'b0;
        else
            zero_pulse_o <= running && tick && (count == DATA_W'(1));
    end

endmodule : interval_timer

// ===== verif/field_source.sv
`timescale 1ns/100ps
module field_source
    import scan_ctrl_pkg::*;
#(
    parameter logic [DATA_W-1:0] ADC_WORD = 16'h3c5a,
    parameter logic [DATA_W-1:0] CARD_SEED = 16'ha500
)
(
    input wire logic clk_i,
    output logic [DATA_W-1:0] adc_data_o,
    output logic [CARD_CHANNELS*DATA_W-1:0] ext_word_o,
    output logic ext_strobe_o
);
    logic [11:0] tick = 12'h000;

    // Words are held steady so any capture phase sees one value
    always_comb
    begin
        adc_data_o = ADC_WORD;
        for (int i = 0; i < CARD_CHANNELS; i++)
            ext_word_o[i*DATA_W +: DATA_W] = CARD_SEED + DATA_W'(i);
    end

    ////////////////////////////////////////
    // Source strobe every 1000 cycles, seen only when wired
    always_ff @(posedge clk_i)
    begin
        tick <= (tick == 12'h3e7) ? 12'h000 : tick + 12'h001;
    end
    assign ext_strobe_o = (tick == 12'h3e7);
endmodule : field_source

// ===== verif/scan_ctrl_chk.sv
`timescale 1ns/100ps
module scan_ctrl_chk
    import scan_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic bic_mux_en_o,
    input wire logic bic_adc_en_o,
    input wire logic bic_data_valid_o,
    input wire logic bic_chan_valid_i,
    input wire logic timer_pulse_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic [11:0] since_start;
    logic [11:0] since_sel;
    logic mux_cmd;
    logic adc_cmd;
    logic chan_sel;
    assign mux_cmd = wr_i && addr_i == OFS_MUX_CMD;
    assign adc_cmd = wr_i && addr_i == OFS_ADC_CMD;
    // Settling runs from the channel change, which may come well before the start
    assign chan_sel = (wr_i && addr_i == OFS_MUX_SELECT)
        || (bic_mux_en_o && bic_chan_valid_i);

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            since_sel <= '0;
        else if (chan_sel)
            since_sel <= '0;
        else if (since_sel != 12'hfff)
            since_sel <= since_sel + 12'h001;
    end

    // Saturates so a long idle spell cannot wrap into a false early start
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            since_start <= '0;
        else if (adc_cmd && wr_data_i[1:0] == FN_START)
            since_start <= '0;
        else if (since_start != 12'hfff)
            since_start <= since_start + 12'h001;
    end

    sequence read_then_idle;
        rd_i ##1 !rd_i;
    endsequence

    ////////////////////////////////////////
    chk_read_idle:
        assert property (read_then_idle |=> rd_data_o == '0)
        else $error("read data held past its cycle");
    chk_read_cause:
        assert property (rd_data_o != '0 |-> $past(rd_i))
        else $error("read data without a read");
    chk_unmapped_zero:
        assert property (rd_i && addr_i == 8'h1c |=> rd_data_o == '0)
        else $error("unmapped read not zero");
    chk_mux_link:
        assert property (mux_cmd && wr_data_i[1:0] == FN_BIC |=> bic_mux_en_o)
        else $error("channel link missing");
    chk_mux_unlink:
        assert property (mux_cmd && (wr_data_i[1:0] == FN_RANDOM
            || wr_data_i[1:0] == FN_SEQUENTIAL) |=> !bic_mux_en_o)
        else $error("channel link kept after mode command");
    chk_adc_link:
        assert property (adc_cmd && wr_data_i[1:0] == FN_BIC |=> bic_adc_en_o [*3])
        else $error("converter link missing");
    chk_link_holds:
        assert property (!$fell(bic_adc_en_o))
        else $error("converter link dropped");
    chk_settle_wait:
        assert property (bic_data_valid_o |-> since_sel >= SETTLE_LOAD
            && since_start <= 12'h834)
        else $error("converted word outside settle window");
    chk_valid_linked:
        assert property (bic_data_valid_o |-> bic_adc_en_o ##1 !bic_data_valid_o)
        else $error("bad controller word strobe");
    chk_pulse_single:
        assert property (timer_pulse_o |=> !timer_pulse_o [*8])
        else $error("timer pulse too long or too close");
endmodule : scan_ctrl_chk

bind digital_input_scan_control scan_ctrl_chk u_chk (.clk_i, .reset_i, .wr_i, .rd_i,
    .addr_i, .wr_data_i, .rd_data_o, .bic_mux_en_o, .bic_adc_en_o,
    .bic_data_valid_o, .bic_chan_valid_i, .timer_pulse_o);

// ===== verif/test_digital_input_scan_control.sv
`timescale 1ns/100ps
module test_digital_input_scan_control
    import scan_ctrl_pkg::*;
;
    localparam logic [15:0] ADC_WORD = 16'h3c5a;
    localparam logic [15:0] CARD_SEED = 16'ha500;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wr_data_i = 16'h0000;
    logic ext_start = 1'b0;
    logic utility = 1'b0;
    logic cont = 1'b0;
    logic trig = 1'b0;
    logic bvalid = 1'b0;
    logic [7:0] bchan = 8'h00;
    logic [15:0] rd_data_o, adc_data, bic_data_o, d;
    logic [63:0] ext_word;
    logic ext_strobe, bic_mux_en_o, bic_adc_en_o, bic_data_valid_o, card_drive_o;
    logic timer_pulse_o;
    int fail_count = 0;
    int samples_checked = 0;

    always #5 clk_i = ~clk_i;

    field_source #(.ADC_WORD(ADC_WORD), .CARD_SEED(CARD_SEED)) u_src (.clk_i(clk_i),
        .adc_data_o(adc_data), .ext_word_o(ext_word), .ext_strobe_o(ext_strobe));

    digital_input_scan_control #(.CARD_BASE(8'h00)) DUT (.clk_i(clk_i), .reset_i(reset_i),
        .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .rd_data_o(rd_data_o), .adc_data_i(adc_data), .ext_word_i(ext_word),
        .ext_strobe_i(ext_strobe), .strobe_ext_sel_i(1'b0), .ext_start_i(ext_start),
        .utility_i(utility), .timer_continuous_i(cont), .timer_trigger_i(trig),
        .bic_chan_valid_i(bvalid), .bic_chan_i(bchan), .bic_mux_en_o(bic_mux_en_o),
        .bic_adc_en_o(bic_adc_en_o), .bic_data_valid_o(bic_data_valid_o),
        .bic_data_o(bic_data_o), .card_drive_o(card_drive_o),
        .timer_pulse_o(timer_pulse_o));

    ////////////////////////////////////////
    task check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task conclude;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rd_data_o;
    endtask : rd

    task wait_ready;
        for (int i = 0; i < 1500; i++)
        begin
            rd(OFS_STATUS, d);
            if (d[ST_DATA_READY] === 1'b1)
                return;
        end
        fail_count++;
        conclude();
    endtask : wait_ready

    task gap(input int lim, output int n);
        for (n = 1; n <= lim; n++)
        begin
            @(posedge clk_i);
            #1;
            if (timer_pulse_o === 1'b1)
                return;
        end
    endtask : gap

    task kick;
        @(posedge clk_i);
        ext_start <= 1'b1;
        @(posedge clk_i);
        ext_start <= 1'b0;
    endtask : kick

    ////////////////////////////////////////
    task reset_case;
        rd(OFS_STATUS, d);
        check(d, 16'h0000);
        rd(8'h1c, d);
        check(d, 16'h0000);
        check(16'(bic_mux_en_o | bic_adc_en_o), 16'h0000);
    endtask : reset_case

    task random_case;
        logic [7:0] s[2];
        logic [15:0] e[2];
        s = '{8'h02, 8'h10};
        e = '{CARD_SEED + 16'h0002, ADC_WORD};
        wr(OFS_MUX_CMD, 16'h0001);
        rd(OFS_DATA_CLEAR, d);
        for (int i = 0; i < 2; i++)
        begin
            wr(OFS_MUX_SELECT, {8'h00, s[i]});
            wr(OFS_ADC_CMD, 16'h0001);
            repeat (1970) @(posedge clk_i);
            rd(OFS_STATUS, d);
            check(16'(d[ST_DATA_READY]), 16'h0000);
            wait_ready();
            rd(OFS_DATA_CLEAR, d);
            check(d, e[i]);
            check(16'(card_drive_o), 16'(i == 0));
            rd(OFS_STATUS, d);
            check(16'(d[ST_DATA_READY]), 16'h0000);
        end
    endtask : random_case

    task ext_case;
        @(posedge clk_i);
        utility <= 1'b1;
        wr(OFS_MUX_SELECT, 16'h0003);
        kick();
        rd(OFS_STATUS, d);
        check(16'(d[ST_BUSY]), 16'h0000);
        check(16'(d[ST_UTILITY]), 16'h0001);
        wr(OFS_ADC_CMD, 16'h0002);
        kick();
        rd(OFS_STATUS, d);
        check(16'(d[ST_BUSY]), 16'h0001);
        wait_ready();
        rd(OFS_DATA_CLEAR, d);
        check(d, CARD_SEED + 16'h0003);
        wr(OFS_ADC_CMD, 16'h0003);
        utility <= 1'b0;
    endtask : ext_case

    task seq_case;
        logic [7:0] c[3];
        c = '{8'h00, 8'h01, 8'h00};
        wr(OFS_MUX_CMD, 16'h0002);
        wr(OFS_MUX_CMD, 16'h0003);
        rd(OFS_STATUS, d);
        check(16'(d[ST_SEQ_MODE]), 16'h0001);
        wr(OFS_MUX_SELECT, 16'h0001);
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_ADC_CMD, 16'h0001);
            rd(OFS_MUX_SELECT, d);
            check(d, {8'h00, c[i]});
            rd(OFS_STATUS, d);
            check(16'(d[ST_END_OF_SCAN]), 16'(c[i] == 8'h01));
            wait_ready();
            rd(OFS_DATA, d);
            check(d, CARD_SEED + 16'(c[i]));
            rd(OFS_STATUS, d);
            check(16'(d[ST_DATA_READY]), 16'h0001);
            rd(OFS_DATA_CLEAR, d);
        end
    endtask : seq_case

    task timer_case;
        int n;
        @(posedge clk_i);
        cont <= 1'b1;
        wr(OFS_TIMER_BUF, 16'h0003);
        gap(400, n);
        check(16'(n > 298 && n < 303), 16'h0001);
        gap(400, n);
        check(16'(n), 16'h012c);
        rd(OFS_STATUS, d);
        check(16'(d[ST_TIMER_ZERO]), 16'h0001);
        rd(OFS_STATUS, d);
        check(16'(d[ST_TIMER_ZERO]), 16'h0000);
        wr(OFS_TIMER_BUF, 16'h0000);
        cont <= 1'b0;
        wr(OFS_TIMER_BUF, 16'h0002);
        gap(300, n);
        check(16'(n > 198 && n < 203), 16'h0001);
        gap(500, n);
        check(16'(n), 16'h01f5);
        @(posedge clk_i);
        trig <= 1'b1;
        @(posedge clk_i);
        trig <= 1'b0;
        gap(300, n);
        check(16'(n < 203), 16'h0001);
        wr(OFS_TIMER_BUF, 16'h0000);
    endtask : timer_case

    task bic_case;
        int i;
        wr(OFS_MUX_CMD, 16'h0000);
        #1;
        check(16'(bic_mux_en_o), 16'h0001);
        rd(OFS_STATUS, d);
        check(16'(d[ST_SEQ_MODE]), 16'h0000);
        @(posedge clk_i);
        bvalid <= 1'b1;
        bchan <= 8'h03;
        @(posedge clk_i);
        bvalid <= 1'b0;
        rd(OFS_MUX_SELECT, d);
        check(d, 16'h0003);
        wr(OFS_ADC_CMD, 16'h0000);
        wr(OFS_ADC_CMD, 16'h0001);
        for (i = 0; i < 2200 && bic_data_valid_o !== 1'b1; i++)
        begin
            @(posedge clk_i);
            #1;
        end
        check(16'(i < 2200), 16'h0001);
        check(bic_data_o, CARD_SEED + 16'h0003);
    endtask : bic_case

    ////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        reset_case();
        random_case();
        ext_case();
        seq_case();
        timer_case();
        bic_case();
        conclude();
    end
endmodule : test_digital_input_scan_control
